/* rtl/daucm_pkg.sv */
package daucm_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'hC0;
   localparam logic [7:0] STAT_ADDR = 8'hC4;
   localparam logic [7:0] TIME_ADDR = 8'hC8;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'hCC;
   localparam logic [7:0] DATA_BASE = 8'hD0;
   localparam logic [7:0] DATA_LAST = 8'hEC;
   localparam logic [7:0] IRQ_CLR_ADDR = 8'hF0;
   localparam logic [7:0] IRQ_ENA_ADDR = 8'hF4;
   // control field positions
   localparam int CTRL_IRQ_ENA_BIT = 5;
   localparam int CTRL_MODE_LSB = 3;
   localparam int CTRL_LOAD_BIT = 2;
   localparam int CTRL_RSTSEL_BIT = 1;
   localparam int CTRL_RST_BIT = 0;
   // status field positions
   localparam int STAT_IRQ_BIT = 2;
   localparam int STAT_SDU_BIT = 1;
   localparam int STAT_SDR_BIT = 0;
   // event status bits
   localparam int EV_LOAD = 0;
   localparam int EV_TICK = 1;
   localparam int EV_TRIG = 2;
   localparam int EV_REQ = 3;
   localparam int EV_W = 4;
   // reset values
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [15:0] MIDSCALE = 16'h8000;
   localparam logic [15:0] TIME_RESET = 16'h0000;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int STEP_US = 100;
   localparam int STEP_CYCLES = STEP_US * CLK_MHZ;

   typedef enum logic [1:0] {
      MODE_IMMEDIATE = 2'b00,
      MODE_SOFTWARE = 2'b01,
      MODE_TIMER = 2'b10,
      MODE_TRIGGER = 2'b11
   } daucm_mode_t;

   typedef struct packed {
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } daucm_req_t;
endpackage

/* rtl/daucm_top.sv */
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module daucm_top #(
   parameter int CHANNELS = 8,
   parameter int STEP_CYCLES = daucm_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external trigger on digital line 1
   input wire logic trigger_line1,
   // converter outputs
   output logic [CHANNELS*16-1:0] dac_out,
   output logic dac_load_pulse,
   // interrupts
   output logic dac_irq,
   output logic irq
);
   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   function automatic logic adr_is(input logic [7:0] adr, input logic [7:0] reg_adr);
      return adr == reg_adr;
   endfunction

   daucm_pkg::daucm_req_t req;
   assign req = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
   wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = access && req.we;
   wire rd_start = access && !req.we;
   wire wr_ctrl = wr && adr_is(req.adr, daucm_pkg::CTRL_ADDR) && req.sel[0];
   wire wr_stat = wr && adr_is(req.adr, daucm_pkg::STAT_ADDR) && req.sel[0];
   wire wr_time = wr && adr_is(req.adr, daucm_pkg::TIME_ADDR);
   wire wr_iclr = wr && adr_is(req.adr, daucm_pkg::IRQ_CLR_ADDR) && req.sel[0];
   wire wr_iena = wr && adr_is(req.adr, daucm_pkg::IRQ_ENA_ADDR) && req.sel[0];
   wire data_hit = req.adr >= daucm_pkg::DATA_BASE && req.adr <= daucm_pkg::DATA_LAST && req.adr[1:0] == 2'b00;
   wire [2:0] data_idx = 3'((req.adr - daucm_pkg::DATA_BASE) >> 2);
   wire wr_data = wr && data_hit;

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic irq_ena_q;
   logic [1:0] mode_q;
   logic rstsel_q;
   logic [15:0] preload_q;
   wire [1:0] mode_wr = wb_dat_i[daucm_pkg::CTRL_MODE_LSB +: 2];
   wire load_cmd = wr_ctrl && wb_dat_i[daucm_pkg::CTRL_LOAD_BIT];
   wire reset_cmd = wr_ctrl && wb_dat_i[daucm_pkg::CTRL_RST_BIT];
   wire timer_select = wr_ctrl && mode_wr == daucm_pkg::MODE_TIMER && mode_q != daucm_pkg::MODE_TIMER;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_ena_q <= 1'b0;
         mode_q <= daucm_pkg::MODE_IMMEDIATE;
         rstsel_q <= 1'b0;
      end else if (wr_ctrl) begin
         irq_ena_q <= wb_dat_i[daucm_pkg::CTRL_IRQ_ENA_BIT];
         mode_q <= mode_wr;
         rstsel_q <= wb_dat_i[daucm_pkg::CTRL_RSTSEL_BIT];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         preload_q <= daucm_pkg::TIME_RESET;
      end else if (wr_time) begin
         if (req.sel[0]) begin
            preload_q[7:0] <= wb_dat_i[7:0];
         end
         if (req.sel[1]) begin
            preload_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // trigger input synchroniser
   // ------------------------------------------------------------
   logic [2:0] trig_sync_q;
   logic trig_level_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trig_sync_q <= 3'b000;
         trig_level_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], trigger_line1};
         if (trig_sync_q[1] == trig_sync_q[2]) begin
            trig_level_q <= trig_sync_q[2];
         end
      end
   end
   wire trig_rise = trig_sync_q[1] && trig_sync_q[2] && !trig_level_q;

   // ------------------------------------------------------------
   // sequencer timer
   // ------------------------------------------------------------
   logic [$clog2(STEP_CYCLES)-1:0] step_q;
   logic [15:0] count_q;
   logic timer_run_q;
   wire step_done = step_q == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1);
   wire timer_zero = timer_run_q && step_done && count_q == 16'h0001;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= '0;
         count_q <= 16'h0000;
         timer_run_q <= 1'b0;
      end else if (timer_select) begin
         step_q <= '0;
         count_q <= preload_q;
         timer_run_q <= preload_q != 16'h0000;
      end else if (mode_q != daucm_pkg::MODE_TIMER) begin
         timer_run_q <= 1'b0;
      end else if (timer_run_q) begin
         step_q <= step_done ? '0 : step_q + 1'b1;
         if (step_done) begin
            count_q <= timer_zero ? preload_q : count_q - 16'h0001;
            timer_run_q <= !(timer_zero && preload_q == 16'h0000);
         end
      end
   end

   // ------------------------------------------------------------
   // update event and buffers
   // ------------------------------------------------------------
   logic update;
   always_comb begin
      case (daucm_pkg::daucm_mode_t'(mode_q))
         daucm_pkg::MODE_SOFTWARE: update = load_cmd;
         daucm_pkg::MODE_TIMER: update = timer_zero;
         daucm_pkg::MODE_TRIGGER: update = trig_rise;
         default: update = 1'b0;
      endcase
   end
   wire immediate = mode_q == daucm_pkg::MODE_IMMEDIATE;

   logic [15:0] buf_q [CHANNELS];
   logic [15:0] out_q [CHANNELS];
   logic load_pulse_q;
   wire imm_write = wr_data && immediate;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         load_pulse_q <= 1'b0;
      end else begin
         load_pulse_q <= update || reset_cmd || imm_write;
      end
   end

   // buffers take every data write, whatever the mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            buf_q[i] <= daucm_pkg::DATA_RESET;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (reset_cmd) begin
               buf_q[i] <= daucm_pkg::MIDSCALE;
            end else if (wr_data && data_idx == 3'(i)) begin
               buf_q[i] <= wb_dat_i[15:0];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            out_q[i] <= daucm_pkg::DATA_RESET;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (reset_cmd) begin
               out_q[i] <= daucm_pkg::MIDSCALE;
            end else if (imm_write && data_idx == 3'(i)) begin
               out_q[i] <= wb_dat_i[15:0];
            end else if (update) begin
               out_q[i] <= buf_q[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         dac_out[i*16 +: 16] = out_q[i];
      end
   end
   assign dac_load_pulse = load_pulse_q;

   // ------------------------------------------------------------
   // sequencer data request and converter interrupt
   // ------------------------------------------------------------
   logic sdr_q;
   logic sdu_q;
   logic pend_q;
   wire deferred_irq_mode = mode_q == daucm_pkg::MODE_TIMER || mode_q == daucm_pkg::MODE_TRIGGER;
   wire sdr_clear = wr_stat && wb_dat_i[daucm_pkg::STAT_SDR_BIT];
   wire request = update && !immediate && mode_q != daucm_pkg::MODE_IMMEDIATE;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdr_q <= 1'b0;
         sdu_q <= 1'b1;
         pend_q <= 1'b0;
      end else begin
         if (request) begin
            sdr_q <= 1'b1;
            sdu_q <= sdr_q;
         end else if (sdr_clear) begin
            sdr_q <= 1'b0;
            sdu_q <= 1'b0;
         end
         if (request && deferred_irq_mode && irq_ena_q) begin
            pend_q <= 1'b1;
         end else if (sdr_clear) begin
            pend_q <= 1'b0;
         end
      end
   end
   assign dac_irq = pend_q;

   // ------------------------------------------------------------
   // event status, enable and interrupt line
   // ------------------------------------------------------------
   logic [daucm_pkg::EV_W-1:0] ev_stat_q;
   logic [daucm_pkg::EV_W-1:0] ev_ena_q;
   logic irq_q;
   wire [daucm_pkg::EV_W-1:0] ev_set = {request, trig_rise, timer_zero, load_cmd};
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ev_stat_q <= '0;
         ev_ena_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ev_stat_q <= ev_set | (ev_stat_q & ~(wr_iclr ? wb_dat_i[daucm_pkg::EV_W-1:0] : '0));
         if (wr_iena) begin
            ev_ena_q <= wb_dat_i[daucm_pkg::EV_W-1:0];
         end
         irq_q <= |(ev_stat_q & ev_ena_q);
      end
   end
   assign irq = irq_q;

   // ------------------------------------------------------------
   // read data and acknowledge
   // ------------------------------------------------------------
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (req.adr == daucm_pkg::CTRL_ADDR) begin
         rdata[daucm_pkg::CTRL_IRQ_ENA_BIT] = irq_ena_q;
         rdata[daucm_pkg::CTRL_MODE_LSB +: 2] = mode_q;
         rdata[daucm_pkg::CTRL_RSTSEL_BIT] = rstsel_q;
      end else if (req.adr == daucm_pkg::STAT_ADDR) begin
         rdata[daucm_pkg::STAT_IRQ_BIT] = pend_q;
         rdata[daucm_pkg::STAT_SDU_BIT] = sdu_q;
         rdata[daucm_pkg::STAT_SDR_BIT] = sdr_q;
      end else if (req.adr == daucm_pkg::TIME_ADDR) begin
         rdata[15:0] = preload_q;
      end else if (req.adr == daucm_pkg::IRQ_STAT_ADDR) begin
         rdata[daucm_pkg::EV_W-1:0] = ev_stat_q;
      end else if (req.adr == daucm_pkg::IRQ_ENA_ADDR) begin
         rdata[daucm_pkg::EV_W-1:0] = ev_ena_q;
      end else if (data_hit) begin
         rdata[15:0] = buf_q[data_idx];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= rd_start ? rdata : 32'h0000_0000;
      end
   end
endmodule

/* sim/daucm_monitor.sv */
`timescale 1ns/1ps
module daucm_monitor #(
   parameter int CHANNELS = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // converter side
   input wire logic trigger_line1,
   input wire logic [CHANNELS*16-1:0] dac_out,
   input wire logic dac_load_pulse,
   input wire logic dac_irq,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire logic ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == daucm_pkg::CTRL_ADDR;
   wire logic ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == daucm_pkg::CTRL_ADDR;
   wire logic sdr_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == daucm_pkg::STAT_ADDR && wb_dat_i[0];
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   a_no_ack: assert property (p_no_ack) else $error("ack without request");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_ctl_upper; ctl_rd |-> wb_dat_o[31:6] == 26'h000_0000; endproperty
   a_ctl_upper: assert property (p_ctl_upper) else $error("control upper bits not zero");
   property p_ctl_wo; ctl_rd |-> !wb_dat_o[2] && !wb_dat_o[0]; endproperty
   a_ctl_wo: assert property (p_ctl_wo) else $error("command bits read back");
   property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i < daucm_pkg::CTRL_ADDR |-> wb_dat_o == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst_mid; ctl_wr && wb_dat_i[0] |-> ##[0:2] dac_out == {CHANNELS{daucm_pkg::MIDSCALE}}; endproperty
   a_rst_mid: assert property (p_rst_mid) else $error("reset command missed midscale");
   property p_sw_load; ctl_wr && wb_dat_i[4:3] == 2'b01 && wb_dat_i[2] && !wb_dat_i[0] |-> ##[0:2] dac_load_pulse; endproperty
   a_sw_load: assert property (p_sw_load) else $error("load command gave no load");
   property p_sdr_clr; sdr_wr |-> ##[0:2] !dac_irq; endproperty
   a_sdr_clr: assert property (p_sdr_clr) else $error("interrupt not acknowledged");
endmodule
bind daucm_top daucm_monitor #(.CHANNELS(CHANNELS)) i_mon (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger_line1(trigger_line1), .dac_out(dac_out),
   .dac_load_pulse(dac_load_pulse), .dac_irq(dac_irq), .irq(irq));

/* sim/daucm_top_tb.sv */
`timescale 1ns/1ps
module daucm_top_tb;
   logic clock, rst_n, cyc, stb, we, trig, ack, dac_irq, irq;
   logic [7:0] adr;
   logic [31:0] dat, rdat, r;
   logic [127:0] dac_out;
   int fail_count = 0;
   int total_checks = 0;
   daucm_top #(.CHANNELS(8), .STEP_CYCLES(4)) i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .trigger_line1(trig), .dac_out(dac_out), .dac_load_pulse(), .dac_irq(dac_irq), .irq(irq));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one classic cycle, held until ack is sampled high or 16 clocks pass
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1) fail_count++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, r);
   endtask
   function automatic logic [31:0] ch(input int i);
      return {16'h0000, dac_out[i*16+:16]};
   endfunction
   task automatic pulse;
      @(posedge clock);
      trig <= 1'b1;
      wt(4);
      trig <= 1'b0;
      wt(8);
   endtask
   task automatic t_reset;
      chk("out0", 32'h0000_0000, ch(0));
      rd(daucm_pkg::CTRL_ADDR, "ctrl", 32'h0000_0000);
      rd(8'h10, "unmapped", 32'h0000_0000);
      wr(daucm_pkg::CTRL_ADDR, 32'hFFFF_FFC0);
      rd(daucm_pkg::CTRL_ADDR, "ctrl upper", 32'h0000_0000);
      wr(8'hDC, 32'h0000_1234);
      wt(2);
      chk("ch3 imm", 32'h0000_1234, ch(3));
      $display("test reset and immediate done");
   endtask
   task automatic t_sw;
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0008);
      wr(8'hD0, 32'h0000_AAAA);
      wt(2);
      chk("ch0 held", 32'h0000_0000, ch(0));
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_000C);
      wt(2);
      chk("ch0 load", 32'h0000_AAAA, ch(0));
      chk("ch3 kept", 32'h0000_1234, ch(3));
      rd(daucm_pkg::CTRL_ADDR, "load clear", 32'h0000_0008);
      rd(daucm_pkg::IRQ_STAT_ADDR, "event status", 32'h0000_0009);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      wr(daucm_pkg::IRQ_ENA_ADDR, 32'h0000_0001);
      wt(2);
      chk("irq on", 32'h0000_0001, {31'h0, irq});
      wr(daucm_pkg::IRQ_CLR_ADDR, 32'h0000_000F);
      wt(2);
      chk("irq clear", 32'h0000_0000, {31'h0, irq});
      wr(daucm_pkg::STAT_ADDR, 32'h0000_0001);
      $display("test software load done");
   endtask
   task automatic t_timer;
      wr(daucm_pkg::TIME_ADDR, 32'h0000_0000);
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0010);
      wr(8'hD8, 32'h0000_7777);
      wt(40);
      chk("no start", 32'h0000_0000, ch(2));
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(daucm_pkg::TIME_ADDR, 32'h0000_0002);
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0030);
      wt(40);
      chk("timer load", 32'h0000_7777, ch(2));
      chk("timer irq", 32'h0000_0001, {31'h0, dac_irq});
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(daucm_pkg::STAT_ADDR, 32'h0000_0001);
      $display("test timer done");
   endtask
   task automatic t_trig;
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0038);
      wr(8'hD4, 32'h0000_5555);
      wt(2);
      chk("ch1 held", 32'h0000_0000, ch(1));
      pulse();
      chk("ch1 trig", 32'h0000_5555, ch(1));
      chk("dac irq", 32'h0000_0001, {31'h0, dac_irq});
      rd(daucm_pkg::STAT_ADDR, "status pending", 32'h0000_0005);
      wr(daucm_pkg::STAT_ADDR, 32'h0000_0001);
      wt(2);
      chk("irq ack", 32'h0000_0000, {31'h0, dac_irq});
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0018);
      pulse();
      chk("irq disabled", 32'h0000_0000, {31'h0, dac_irq});
      rd(daucm_pkg::STAT_ADDR, "status masked", 32'h0000_0001);
      wr(daucm_pkg::CTRL_ADDR, 32'h0000_0001);
      wt(2);
      for (int i = 0; i < 8; i++) chk("midscale", {16'h0000, daucm_pkg::MIDSCALE}, ch(i));
      rd(daucm_pkg::CTRL_ADDR, "rst clear", 32'h0000_0000);
      $display("test trigger and reset command done");
   endtask
   initial begin
      {rst_n, cyc, stb, we, trig} = 5'h00;
      adr = 8'h00;
      dat = 32'h0000_0000;
      wt(8);
      rst_n <= 1'b1;
      t_reset();
      t_sw();
      t_timer();
      t_trig();
      tally_and_finish();
   end
   initial begin
      wt(4000);
      fail_count++;
      tally_and_finish();
   end
endmodule
